// ===== hdl/rcx_pkg.sv
// constants for the radio coexistence signalling block
// assumes a single 40 MHz system clock
package rcx_pkg;
  localparam int unsigned RCX_CLK_HZ = 40000000;
  localparam int unsigned RCX_SYNC_STAGES = 2;
  localparam logic RCX_MARK_RST = 1'b0;
  localparam logic RCX_ACTIVE_RST = 1'b0;
  localparam logic [1:0] RCX_SYNC_RST = 2'h0;
  localparam logic RCX_COMP_RST = 1'b0;
  localparam logic RCX_LNA_RST = 1'b0;
  localparam logic RCX_OE_RST = 1'b0;
  localparam int unsigned RCX_COMP_LAT = 3;
  typedef enum logic {RCX_SRC_CELL, RCX_SRC_SAT} rcx_src_t;
endpackage

// ===== hdl/rcx_sync.sv
// two-stage synchroniser for the companion activity level
// assumes the input may change at any time relative to clk_sys
`timescale 1ns/1ps
`default_nettype none
module rcx_sync
  import rcx_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic clk_en,
  // level
  input wire logic async_in,
  output logic sync_out
);
  logic [1:0] stage_q;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      stage_q <= RCX_SYNC_RST;
    end else if (clk_en) begin
      stage_q <= {stage_q[0], async_in};
    end
  end

  assign sync_out = stage_q[1];
endmodule
`default_nettype wire

// ===== hdl/rcx_coex.sv
// radio coexistence signalling: activity in, time mark out, activity/grant out
// assumes modem core supplies time mark pulses and transceiver state on clk_sys
// Notes on behaviour
// [R01] The interface is exactly three pins, used only to avoid interference with one companion.
// [R02] The companion drives its activity pin high while its transceiver is on.
// [R03] With the satellite receiver in use the activity pin may instead enable an external LNA.
// [R04] The time mark pin carries an active-high pulse aligned to cellular system time.
// [R05] With the satellite receiver in use the time mark carries the satellite one-second mark.
// [R06] The modem activity pin is high while the modem transceiver is on, low while off.
// [R07] The modem activity pin low is a grant letting the companion transmit and receive.
// [R08] The companion activity input passes a two-stage synchroniser before use.
`timescale 1ns/1ps
`default_nettype none
module rcx_coex
  import rcx_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic clk_en,
  // modem core side
  input wire logic sat_rx_in_use,
  input wire logic lna_mode_en,
  input wire logic cell_mark_pulse,
  input wire logic sat_pps_pulse,
  input wire logic modem_trx_on,
  output logic companion_active,
  output logic lna_enable,
  // coexistence pins
  input wire logic companion_active_in,
  output logic companion_active_oe,
  output logic time_mark_out,
  output logic modem_active_grant_out
);
  logic comp_sync;
  logic comp_act_q;
  logic lna_q;
  logic lna_oe_q;
  logic mark_q;
  logic active_q;
  rcx_src_t src;
  logic mark_d;
  logic lna_sel;
  logic comp_act_d;
  logic lna_d;
  logic lna_oe_d;
  logic active_d;

  // [R08] two stages ahead of any use
  rcx_sync u_sync (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .async_in(companion_active_in),
    .sync_out(comp_sync)
  );

  // mark source follows the satellite receiver state
  assign src = sat_rx_in_use ? RCX_SRC_SAT : RCX_SRC_CELL;
  assign lna_sel = sat_rx_in_use & lna_mode_en;
  assign mark_d = (src == RCX_SRC_SAT) ? sat_pps_pulse : cell_mark_pulse; // [R04] [R05]
  // companion level masked while the pin drives the amplifier
  assign comp_act_d = comp_sync & ~lna_sel; // [R02]
  assign lna_d = lna_sel; // [R03]
  assign lna_oe_d = lna_sel; // [R03]
  assign active_d = modem_trx_on; // [R06] [R07]

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      comp_act_q <= RCX_COMP_RST;
    end else if (clk_en) begin
      comp_act_q <= comp_act_d;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      lna_q <= RCX_LNA_RST;
    end else if (clk_en) begin
      lna_q <= lna_d;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      lna_oe_q <= RCX_OE_RST;
    end else if (clk_en) begin
      lna_oe_q <= lna_oe_d;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      mark_q <= RCX_MARK_RST;
    end else if (clk_en) begin
      mark_q <= mark_d;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      active_q <= RCX_ACTIVE_RST;
    end else if (clk_en) begin
      active_q <= active_d;
    end
  end

  // [R01] only three coexistence pins leave the block
  assign companion_active = comp_act_q;
  assign lna_enable = lna_q;
  assign companion_active_oe = lna_oe_q;
  assign time_mark_out = mark_q;
  assign modem_active_grant_out = active_q;

  property p_sync_delay;
    @(posedge clk_sys) disable iff (!rst_n)
      (clk_en && !lna_sel) [*3] |=> companion_active == $past(companion_active_in, RCX_COMP_LAT);
  endproperty
  a_sync_delay: assert property (p_sync_delay) else $error("companion sync delay wrong"); // [R08]

  property p_lna;
    @(posedge clk_sys) disable iff (!rst_n)
      (clk_en && lna_sel) |=> (lna_enable && companion_active_oe && !companion_active);
  endproperty
  a_lna: assert property (p_lna) else $error("lna mode not applied"); // [R03]

  property p_cell_mark;
    @(posedge clk_sys) disable iff (!rst_n)
      (clk_en && !sat_rx_in_use) |=> time_mark_out == $past(cell_mark_pulse);
  endproperty
  a_cell_mark: assert property (p_cell_mark) else $error("cell mark mismatch"); // [R04]

  property p_sat_mark;
    @(posedge clk_sys) disable iff (!rst_n)
      (clk_en && sat_rx_in_use) |=> time_mark_out == $past(sat_pps_pulse);
  endproperty
  a_sat_mark: assert property (p_sat_mark) else $error("pps mark mismatch"); // [R05]

  property p_active;
    @(posedge clk_sys) disable iff (!rst_n)
      clk_en |=> modem_active_grant_out == $past(modem_trx_on);
  endproperty
  a_active: assert property (p_active) else $error("activity level mismatch"); // [R06]

  property p_grant;
    @(posedge clk_sys) disable iff (!rst_n)
      (clk_en && !modem_trx_on) ##1 (clk_en && !modem_trx_on) |=> !modem_active_grant_out [*1];
  endproperty
  a_grant: assert property (p_grant) else $error("grant not given while off"); // [R07]

  property p_freeze;
    @(posedge clk_sys) disable iff (!rst_n)
      !clk_en |=> $stable(time_mark_out) && $stable(modem_active_grant_out);
  endproperty
  a_freeze: assert property (p_freeze) else $error("state moved with enable low"); // [R01]

  property p_comp_level;
    @(posedge clk_sys) disable iff (!rst_n)
      (clk_en && !lna_sel && comp_sync) |=> companion_active;
  endproperty
  a_comp_level: assert property (p_comp_level) else $error("companion level lost"); // [R02]

  property p_sync_low;
    @(posedge clk_sys) disable iff (!rst_n)
      (clk_en && !lna_sel && !comp_sync) |=> !companion_active;
  endproperty
  a_sync_low: assert property (p_sync_low) else $error("companion level stuck high"); // [R02]

  property p_lna_exit;
    @(posedge clk_sys) disable iff (!rst_n)
      (clk_en && !lna_sel) |=> (!lna_enable && !companion_active_oe);
  endproperty
  a_lna_exit: assert property (p_lna_exit) else $error("pin still driven after lna mode"); // [R03]

  property p_lna_sat_only;
    @(posedge clk_sys) disable iff (!rst_n)
      (clk_en && !sat_rx_in_use) |=> !companion_active_oe;
  endproperty
  a_lna_sat_only: assert property (p_lna_sat_only) else $error("pin driven without sat"); // [R03]

  property p_lna_mode_only;
    @(posedge clk_sys) disable iff (!rst_n)
      (clk_en && !lna_mode_en) |=> !lna_enable;
  endproperty
  a_lna_mode_only: assert property (p_lna_mode_only) else $error("lna on without mode"); // [R03]

  property p_oe_masks;
    @(posedge clk_sys) disable iff (!rst_n)
      companion_active_oe |-> !companion_active;
  endproperty
  a_oe_masks: assert property (p_oe_masks) else $error("own drive seen as companion"); // [R03]

  property p_pin_freeze;
    @(posedge clk_sys) disable iff (!rst_n)
      !clk_en |=> ($stable(companion_active) && $stable(lna_enable) && $stable(companion_active_oe));
  endproperty
  a_pin_freeze: assert property (p_pin_freeze) else $error("pin state moved with enable low"); // [R03]

  property p_mark_quiet;
    @(posedge clk_sys) disable iff (!rst_n)
      (clk_en && !cell_mark_pulse && !sat_pps_pulse) |=> !time_mark_out;
  endproperty
  a_mark_quiet: assert property (p_mark_quiet) else $error("mark without any source"); // [R04]

  property p_pps_masks_cell;
    @(posedge clk_sys) disable iff (!rst_n)
      (clk_en && sat_rx_in_use && cell_mark_pulse && !sat_pps_pulse) |=> !time_mark_out;
  endproperty
  a_pps_masks_cell: assert property (p_pps_masks_cell) else $error("cell mark leaked"); // [R05]

  property p_cell_masks_pps;
    @(posedge clk_sys) disable iff (!rst_n)
      (clk_en && !sat_rx_in_use && sat_pps_pulse && !cell_mark_pulse) |=> !time_mark_out;
  endproperty
  a_cell_masks_pps: assert property (p_cell_masks_pps) else $error("pps mark leaked"); // [R04]

  property p_pps_pulse;
    @(posedge clk_sys) disable iff (!rst_n)
      (clk_en && sat_rx_in_use && sat_pps_pulse) |=> time_mark_out;
  endproperty
  a_pps_pulse: assert property (p_pps_pulse) else $error("pps mark missing"); // [R05]

  property p_busy;
    @(posedge clk_sys) disable iff (!rst_n)
      (clk_en && modem_trx_on) |=> modem_active_grant_out;
  endproperty
  a_busy: assert property (p_busy) else $error("grant given while modem on"); // [R07]
endmodule
`default_nettype wire

// ===== tb/rcx_companion.sv
// companion radio model for the coexistence pins
// assumes grant_n comes straight from the modem activity pin
`timescale 1ns/1ps
`default_nettype none
module rcx_companion (
  input wire logic clk_sys,
  input wire logic want_on,
  input wire logic grant_n,
  output logic active_out
);
  // on only while granted, level follows transceiver state
  always_ff @(posedge clk_sys) active_out <= want_on & ~grant_n;
endmodule
`default_nettype wire

// ===== tb/radio_coexistence_signals_tb.sv
// random self-checking bench for rcx_coex
// assumes inputs change at the falling edge
`timescale 1ns/1ps
`default_nettype none
module radio_coexistence_signals_tb;
  import rcx_pkg::*;
  logic clk_sys = 0, rst_n = 0, clk_en = 0, sat = 0, lna = 0;
  logic cm = 0, sp = 0, trx = 0, want = 0, etm = 0, egr = 0, lmode = 0;
  wire logic ca, le, oe, tm, gr, drv, pin;
  int n_mismatch = 0, tests_run = 0, cyc = 0;
  logic q[$];
  always #12.5 clk_sys = ~clk_sys;
  // pin level: block drives it in lna mode
  assign pin = oe ? le : drv;
  rcx_companion PART (.clk_sys(clk_sys), .want_on(want), .grant_n(gr), .active_out(drv));
  rcx_coex DUT (.clk_sys(clk_sys), .rst_n(rst_n), .clk_en(clk_en), .sat_rx_in_use(sat),
    .lna_mode_en(lna), .cell_mark_pulse(cm), .sat_pps_pulse(sp), .modem_trx_on(trx),
    .companion_active(ca), .lna_enable(le), .companion_active_in(pin),
    .companion_active_oe(oe), .time_mark_out(tm), .modem_active_grant_out(gr));
  task automatic chk(input logic seen, input logic exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop();
    $display("compares=%0d mismatches=%0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // reference model, advances on enabled edges only
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc > 2000) begin
      n_mismatch++;
      report_and_stop();
    end else if (!rst_n) begin
      etm = 1'b0;
      egr = 1'b0;
      lmode = 1'b0;
      q.delete();
    end else if (clk_en) begin
      etm = sat ? sp : cm;
      egr = trx;
      lmode = sat & lna;
      q.push_back(pin);
      if (q.size() > 3) q.pop_front();
      if (lmode) q.delete();
    end
  end
  initial begin
    void'($urandom(22));
    repeat (6) @(negedge clk_sys);
    chk(gr | tm | ca | oe | le, 1'b0);
    rst_n = 1;
    clk_en = 1;
    for (int ph = 0; ph < 2; ph++) begin
      for (int i = 0; i < 500; i++) begin
        @(negedge clk_sys);
        chk(tm, etm);
        chk(gr, egr);
        chk(oe, lmode);
        chk(le, lmode);
        if (q.size() == 3) chk(ca, q[0]);
        if (ph == 1 && i > 4) chk(ca, 1'b0);
        clk_en = ($urandom % 8) != 0;
        sat = ph == 1 ? 1'b1 : 1'($urandom);
        lna = 1'(ph);
        cm = 1'($urandom);
        sp = 1'($urandom);
        trx = 1'($urandom);
        want = 1'($urandom);
      end
      $display("test %0d done", ph);
      // mid-run reset between the phases
      if (ph == 0) begin
        rst_n = 0;
        repeat (2) @(negedge clk_sys);
        chk(gr | tm | ca | oe | le, 1'b0);
        rst_n = 1;
      end
    end
    report_and_stop();
  end
endmodule
`default_nettype wire
